// ==== sim/fcs_flash_host_props.sv ====
// Concurrent checks on the ports of the flash host controller.
`timescale 1ns/1ps
module fcs_flash_host_props #(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic [3:0] cmdOp,
  input wire logic cmdCfi,
  input wire logic highVoltageOk,
  input wire logic rspValid,
  input wire logic rspRefused,
  input wire logic singlePulseMode,
  input wire logic idMode,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic [DATA_W-1:0] dqOut,
  input wire logic dqOe,
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic taken;
  // A non-CFI request is taken when both sides of the handshake agree.
  assign taken = cmdValid && cmdReady && !cmdCfi;

  a_dual_refused: assert property (taken && !highVoltageOk &&
    cmdOp == fcs_pkg::FCS_OP_DUAL |=> rspValid && rspRefused && ceN)
    else $error("dual not refused");
  a_pulse_refused: assert property (taken && !singlePulseMode &&
    cmdOp == fcs_pkg::FCS_OP_SINGLE_PULSE_WRITE |=> rspRefused && ceN)
    else $error("pulse write not refused");
  a_refused_valid: assert property (rspRefused |-> rspValid)
    else $error("refusal without response");
  a_write_drive: assert property (!weN |-> dqOe && !ceN && oeN)
    else $error("write strobe undriven");
  a_read_release: assert property (!oeN |-> !dqOe && weN && !ceN)
    else $error("read strobe while data is driven");
  a_strobe_width: assert property ($fell(weN) |-> ##1 !weN ##1 weN)
    else $error("bad write strobe width");
  a_unlock_pair: assert property ($fell(weN) && dqOut[7:0] == 8'haa &&
    flashAddr[11:0] == 12'h555 |-> ##[1:12] ($fell(weN) &&
    flashAddr[11:0] == 12'haaa && dqOut[7:0] == 8'h55))
    else $error("second unlock write missing");
  a_id_exit: assert property (taken &&
    cmdOp == fcs_pkg::FCS_OP_ID_EXIT |-> ##[1:40] !idMode)
    else $error("id mode not left");
  a_pulse_enter: assert property (taken &&
    cmdOp == fcs_pkg::FCS_OP_SINGLE_PULSE_ENTER |-> ##[1:60] singlePulseMode)
    else $error("pulse mode not entered");
  c_refused: cover property (rspRefused);
  c_pulse: cover property ($rose(singlePulseMode));
  c_id_left: cover property ($fell(idMode));
endmodule : fcs_flash_host_props

bind fcs_flash_host fcs_flash_host_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  u_props (.*);

// ==== sim/fcs_flash_model.sv ====
// Behavioural flash device that decodes host command sequences.
`timescale 1ns/1ps
module fcs_flash_model (
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic [20:0] addr,
  input wire logic [15:0] dq,
  output logic [15:0] dqIn
);
  logic [15:0] mem [logic [20:0]];
  logic [2:0] step = 3'h0;
  logic [7:0] cmd = 8'h00;
  logic [7:0] cfg = 8'h00;
  logic idMode = 1'b0, spMode = 1'b0, bLocked = 1'b0;
  logic suspended = 1'b0, chipErased = 1'b0;
  logic [20:0] erasedSector = '0, lockedSector = '0;
  logic [20:0] protAddr = '0, pendA = '0;
  logic [15:0] pendD = '0;
  logic [15:0] lastOut = 16'h0000;
  logic [10:0] a;
  logic [7:0] d;
  int nWrites = 0;

  // Each write strobe advances the sequence or abandons it.
  always @(posedge weN) begin
    if (!ceN) begin
      a = addr[10:0];
      d = dq[7:0];
      nWrites++;
      case (step)
        3'h0: begin
          if (a == 11'h555 && d == 8'haa) step = 3'h1;
          else if (d == 8'hb0) suspended = 1'b1;
          else if (d == 8'h30) suspended = 1'b0;
          else if (d == 8'h98 && a[7:0] == 8'h55) idMode = 1'b1;
          else if (idMode) idMode = 1'b0;
          else if (spMode) mem[addr] = dq;
        end
        3'h1: step = (a == 11'h2aa && d == 8'h55) ? 3'h2 : 3'h0;
        3'h2: begin
          cmd = d;
          step = (a == 11'h555) ? 3'h3 : 3'h0;
          if (step == 3'h3 && d == 8'h90) idMode = 1'b1;
          if (step == 3'h3 && d == 8'hf0) idMode = 1'b0;
          if (d == 8'h90 || d == 8'hf0) step = 3'h0;
        end
        3'h3: begin
          step = 3'h0;
          case (cmd)
            8'ha0: mem[addr] = dq;
            8'hc0: if (a == 11'h080) bLocked |= !d[1];
              else protAddr = addr;
            8'hd0: cfg = d;
            8'he0: {pendA, pendD, step} = {addr, dq, 3'h4};
            8'h80: if (a == 11'h555 && d == 8'haa) step = 3'h4;
            default: step = 3'h0;
          endcase
        end
        3'h4: begin
          step = (a == 11'h2aa && d == 8'h55) ? 3'h5 : 3'h0;
          if (cmd == 8'he0 && (addr ^ pendA) == 21'h1) begin
            mem[pendA] = pendD;
            mem[addr] = dq;
          end
          if (cmd == 8'he0) step = 3'h0;
        end
        default: begin
          step = 3'h0;
          if (d == 8'h10 && a == 11'h555) chipErased = 1'b1;
          if (d == 8'h30) erasedSector = addr;
          if (d == 8'ha0 && a == 11'h555) spMode = 1'b1;
          if (d == 8'h60) lockedSector = addr;
        end
      endcase
    end
  end

  // Reads at address 80 give the block B status word in identification mode.
  always @(negedge oeN) begin
    if (!ceN) begin
      lastOut = mem.exists(addr) ? mem[addr] : 16'hffff;
      if (idMode && addr[7:0] == 8'h80) begin
        lastOut = {14'h3fff, !bLocked, 1'b1};
      end
    end
  end

  // A released bus shows the inverse of the last value driven.
  assign dqIn = (!oeN && !ceN) ? lastOut : ~lastOut;
endmodule : fcs_flash_model

// ==== sim/testbench.sv ====
// Self-checking testbench for the flash host with a device model.
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0, rst = 1'b1, cmdValid = 1'b0, cmdCfi = 1'b0;
  logic cmdExitLong = 1'b0, highVoltageOk = 1'b0;
  logic [3:0] cmdOp = 4'h0;
  logic [20:0] first_pair_address = '0;
  logic [15:0] first_pair_data = '0, second_pair_data = '0;
  logic cmdReady, rspValid, rspRefused, block_b_lock_bit, singlePulseMode;
  logic idMode, dqOe, ceN, oeN, weN, gotRef;
  logic [15:0] rspData, dqIn, dqOut, gotData;
  logic [20:0] flashAddr;
  int nErrors = 0, checked = 0, cycles = 0, n0;

  fcs_flash_host u_dut (.*);
  fcs_flash_model u_dev (.ceN(ceN), .oeN(oeN), .weN(weN),
    .addr(flashAddr), .dq(dqOut), .dqIn(dqIn));

  // Clock and a timeout that cuts a hang short.
  always #25 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      nErrors++;
      wrap_up();
    end
  end

  task automatic check_bit(input string name, input logic exp, got);
    checked++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected %s: expected %b, seen %b", name, exp, got);
    end
  endtask : check_bit

  task automatic check_word(input string name, input logic [20:0] exp, got);
    checked++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check_word

  // Issues one request and waits for its response pulse.
  task automatic run_op(input logic [3:0] op, input logic [20:0] a,
    input logic [15:0] d);
    int n;
    cmdOp = op;
    first_pair_address = a;
    first_pair_data = d;
    cmdValid = 1'b1;
    while (!cmdReady) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1 cmdValid = 1'b0;
    for (n = 0; rspValid !== 1'b1 && n < 300; n++) @(posedge clock) #1;
    if (n >= 300) nErrors++;
    gotRef = rspRefused;
    gotData = rspData;
  endtask : run_op

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // Main sequence of command scenarios.
  initial begin
    repeat (5) @(posedge clock);
    #1 rst = 1'b0;
    check_bit("lock bit", 1'b1, block_b_lock_bit);
    check_word("config", 21'h0, 21'(u_dev.cfg));
    run_op(fcs_pkg::FCS_OP_PROGRAM, 21'h12345, 16'hbeef);
    check_word("program", 21'hbeef, 21'(u_dev.mem[21'h12345]));
    run_op(fcs_pkg::FCS_OP_READ, 21'h12345, 16'h0);
    check_word("read", 21'hbeef, 21'(gotData));
    n0 = u_dev.nWrites;
    run_op(fcs_pkg::FCS_OP_DUAL, 21'h00100, 16'h1111);
    check_bit("dual refused", 1'b1, gotRef);
    check_bit("quiet bus", 1'b1, n0 == u_dev.nWrites);
    highVoltageOk = 1'b1;
    second_pair_data = 16'h2222;
    run_op(fcs_pkg::FCS_OP_DUAL, 21'h00100, 16'h1111);
    check_word("dual 1", 21'h1111, 21'(u_dev.mem[21'h00100]));
    check_word("dual 2", 21'h2222, 21'(u_dev.mem[21'h00101]));
    run_op(fcs_pkg::FCS_OP_CONFIG, 21'h1f0000, 16'h0001);
    check_word("config", 21'h1, 21'(u_dev.cfg));
    run_op(fcs_pkg::FCS_OP_CHIP_ERASE, 21'h0, 16'h0);
    check_bit("chip erase", 1'b1, u_dev.chipErased);
    run_op(fcs_pkg::FCS_OP_SECTOR_ERASE, 21'h40123, 16'h0);
    check_word("sector", 21'h40123, u_dev.erasedSector);
    run_op(fcs_pkg::FCS_OP_LOCKDOWN, 21'h80000, 16'h0);
    check_word("lockdown", 21'h80000, u_dev.lockedSector);
    run_op(fcs_pkg::FCS_OP_SUSPEND, 21'h777, 16'h0);
    check_bit("suspend", 1'b1, u_dev.suspended);
    run_op(fcs_pkg::FCS_OP_RESUME, 21'h777, 16'h0);
    check_bit("resume", 1'b0, u_dev.suspended);
    for (int i = 0; i < 3; i++) begin
      cmdCfi = (i == 2);
      run_op(fcs_pkg::FCS_OP_ID_ENTRY, 21'h0, 16'h0);
      check_bit("id entry", 1'b1, idMode & u_dev.idMode);
      cmdCfi = 1'b0;
      cmdExitLong = (i == 0);
      run_op(fcs_pkg::FCS_OP_ID_EXIT, 21'h1234, 16'h0);
      check_bit("id exit", 1'b0, idMode | u_dev.idMode);
    end
    run_op(fcs_pkg::FCS_OP_PROT_PROGRAM, 21'h00085, 16'h1234);
    check_word("prot addr", 21'h00085, u_dev.protAddr);
    for (int i = 0; i < 2; i++) begin
      if (i == 1) run_op(fcs_pkg::FCS_OP_BLOCK_B_LOCK, 21'h0, 16'h0);
      run_op(fcs_pkg::FCS_OP_BLOCK_B_STATUS, 21'h0, 16'h0);
      check_bit("lock bit", i == 0, block_b_lock_bit);
      check_word("status", i ? 21'hfffd : 21'hffff, 21'(gotData));
      run_op(fcs_pkg::FCS_OP_ID_EXIT, 21'h0, 16'h0);
    end
    run_op(fcs_pkg::FCS_OP_SINGLE_PULSE_WRITE, 21'h2000, 16'h5a5a);
    check_bit("pulse refused", 1'b1, gotRef);
    run_op(fcs_pkg::FCS_OP_SINGLE_PULSE_ENTER, 21'h0, 16'h0);
    check_bit("pulse mode", 1'b1, singlePulseMode & u_dev.spMode);
    run_op(fcs_pkg::FCS_OP_SINGLE_PULSE_WRITE, 21'h2000, 16'h5a5a);
    check_word("pulse write", 21'h5a5a, 21'(u_dev.mem[21'h2000]));
    wrap_up();
  end
endmodule : testbench

// ==== verilog/fcs_bus_cycle.sv ====
// One asynchronous flash bus cycle: setup, strobe, hold.
`timescale 1ns/1ps
module fcs_bus_cycle (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic isRead,
  input wire logic [fcs_pkg::ADDR_W-1:0] addr,
  input wire logic [fcs_pkg::DATA_W-1:0] wdata,
  input wire logic [fcs_pkg::DATA_W-1:0] dqIn,
  output logic busy,
  output logic done,
  output logic [fcs_pkg::DATA_W-1:0] rdata,
  output logic [fcs_pkg::ADDR_W-1:0] flashAddr,
  output logic [fcs_pkg::DATA_W-1:0] dqOut,
  output logic dqOe,
  output logic ceN,
  output logic oeN,
  output logic weN
);
  typedef enum logic [1:0] {
    FCS_CY_IDLE = 2'b00,
    FCS_CY_SETUP = 2'b01,
    FCS_CY_STROBE = 2'b10,
    FCS_CY_HOLD = 2'b11
  } fcs_cy_e;
  fcs_cy_e state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic rd_reg, rd_next;
  logic [fcs_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [fcs_pkg::DATA_W-1:0] wd_reg, wd_next, rdata_reg, rdata_next;
  logic ceN_reg, ceN_next, oeN_reg, oeN_next, weN_reg, weN_next;
  logic done_reg, done_next;

  // Next state of the strobe sequencer.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rd_next = rd_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    rdata_next = rdata_reg;
    ceN_next = ceN_reg;
    oeN_next = oeN_reg;
    weN_next = weN_reg;
    done_next = 1'b0;
    unique case (state_reg)
      FCS_CY_IDLE: if (start) begin
        state_next = FCS_CY_SETUP;
        cnt_next = 4'(fcs_pkg::T_SETUP_CYC - 1);
        rd_next = isRead;
        addr_next = addr;
        wd_next = wdata;
        ceN_next = 1'b0;
      end
      FCS_CY_SETUP: if (cnt_reg == 4'h0) begin
        state_next = FCS_CY_STROBE;
        cnt_next = 4'(fcs_pkg::T_STROBE_CYC - 1);
        oeN_next = ~rd_reg;
        weN_next = rd_reg;
      end else cnt_next = cnt_reg - 4'h1;
      FCS_CY_STROBE: if (cnt_reg == 4'h0) begin
        state_next = FCS_CY_HOLD;
        cnt_next = 4'(fcs_pkg::T_HOLD_CYC - 1);
        if (rd_reg) rdata_next = dqIn;
        oeN_next = 1'b1;
        weN_next = 1'b1;
      end else cnt_next = cnt_reg - 4'h1;
      FCS_CY_HOLD: if (cnt_reg == 4'h0) begin
        state_next = FCS_CY_IDLE;
        ceN_next = 1'b1;
        done_next = 1'b1;
      end else cnt_next = cnt_reg - 4'h1;
    endcase
  end

  // Registers of the strobe sequencer.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= FCS_CY_IDLE;
      cnt_reg <= 4'h0;
      rd_reg <= 1'b0;
      addr_reg <= '0;
      wd_reg <= '0;
      rdata_reg <= '0;
      ceN_reg <= 1'b1;
      oeN_reg <= 1'b1;
      weN_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rd_reg <= rd_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      rdata_reg <= rdata_next;
      ceN_reg <= ceN_next;
      oeN_reg <= oeN_next;
      weN_reg <= weN_next;
      done_reg <= done_next;
    end
  end

  // Data lines are driven for writes from setup through hold.
  assign busy = (state_reg != FCS_CY_IDLE);
  assign done = done_reg;
  assign rdata = rdata_reg;
  assign flashAddr = addr_reg;
  assign dqOut = wd_reg;
  assign dqOe = busy && !rd_reg;
  assign ceN = ceN_reg;
  assign oeN = oeN_reg;
  assign weN = weN_reg;
endmodule : fcs_bus_cycle

// ==== verilog/fcs_flash_host.sv ====
// Host controller issuing flash command sequences on the parallel bus.
`timescale 1ns/1ps
// Function
// - Multi-cycle commands open AA@555, 55@AAA, then command code at 555.
// - Extended group repeats unlock; 10@555 chip erase, 30@sector erases.
// - Extended group sixth write A0@555 enters single-pulse program mode.
// - Single-pulse mode programs with one address/data write, no prefix.
// - Dual program is five cycles: unlock, E0, two address/data writes.
// - Dual program needs high program voltage; addresses differ only in A0.
// - One write B0 at any address suspends erase or program.
// - One write 30 at any address resumes suspended operation.
// - Other exit bytes accepted by device; host always sends F0.
// - Protection register program: unlock, C0, then address/data write.
// - Block B lock: unlock, C0, then write to 080 with bit 1 zero.
// - Block B status: unlock, 90, then read at address 80.
// - Configuration set: unlock, D0, then write 00 or 01 anywhere.
// - Single write 98@55 enters CFI query; left with identification exit.
module fcs_flash_host #(
  parameter int ADDR_W = fcs_pkg::ADDR_W,
  parameter int DATA_W = fcs_pkg::DATA_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [3:0] cmdOp,
  input wire logic cmdCfi,
  input wire logic cmdExitLong,
  input wire logic [ADDR_W-1:0] first_pair_address,
  input wire logic [DATA_W-1:0] first_pair_data,
  input wire logic [DATA_W-1:0] second_pair_data,
  input wire logic highVoltageOk,
  output logic rspValid,
  output logic rspRefused,
  output logic [DATA_W-1:0] rspData,
  output logic block_b_lock_bit,
  output logic singlePulseMode,
  output logic idMode,
  output logic [ADDR_W-1:0] flashAddr,
  input wire logic [DATA_W-1:0] dqIn,
  output logic [DATA_W-1:0] dqOut,
  output logic dqOe,
  output logic ceN,
  output logic oeN,
  output logic weN
);
  typedef enum logic [1:0] {
    FCS_IDLE = 2'b00,
    FCS_ISSUE = 2'b01,
    FCS_WAIT = 2'b10,
    FCS_DONE = 2'b11
  } fcs_state_e;

  fcs_state_e state_reg, state_next;
  fcs_pkg::fcs_op_e op_reg, op_next;
  logic cfi_reg, cfi_next;
  logic exit_reg, exit_next;
  logic [2:0] step_reg, step_next;
  logic [ADDR_W-1:0] addrA_reg, addrA_next;
  logic [DATA_W-1:0] dataA_reg, dataA_next, dataB_reg, dataB_next;
  logic [DATA_W-1:0] rsp_reg, rsp_next;
  logic rspValid_reg, rspValid_next, refused_reg, refused_next;
  logic lockBit_reg, lockBit_next;
  logic spm_reg, spm_next, idm_reg, idm_next;

  logic [ADDR_W-1:0] stepAddr;
  logic [DATA_W-1:0] stepData;
  logic stepRead;
  logic [2:0] stepCount;
  logic cyStart, cyBusy, cyDone;
  logic [DATA_W-1:0] cyData;
  logic refuse;
  fcs_pkg::fcs_op_e reqOp;

  assign reqOp = fcs_pkg::fcs_op_e'(cmdOp);

  // Step table for the operation held.
  fcs_seq_rom u_rom (
    .op(op_reg),
    .step(step_reg),
    .cfiOp(cfi_reg),
    .exitLong(exit_reg),
    .addrA(addrA_reg),
    .addrB(addrA_reg),
    .dataA(dataA_reg),
    .dataB(dataB_reg),
    .stepAddr(stepAddr),
    .stepData(stepData),
    .stepRead(stepRead),
    .stepCount(stepCount)
  );

  // Pin-level sequencer for each bus cycle.
  fcs_bus_cycle u_cycle (
    .clock(clock),
    .rst(rst),
    .start(cyStart),
    .isRead(stepRead),
    .addr(stepAddr),
    .wdata(stepData),
    .dqIn(dqIn),
    .busy(cyBusy),
    .done(cyDone),
    .rdata(cyData),
    .flashAddr(flashAddr),
    .dqOut(dqOut),
    .dqOe(dqOe),
    .ceN(ceN),
    .oeN(oeN),
    .weN(weN)
  );

  // Dual program without high voltage is refused, and single-pulse writes
  // are refused unless the device was put into that mode.
  assign refuse = (!cmdCfi && reqOp == fcs_pkg::FCS_OP_DUAL &&
                   !highVoltageOk) ||
                  (!cmdCfi && reqOp == fcs_pkg::FCS_OP_SINGLE_PULSE_WRITE &&
                   !spm_reg);
  assign cmdReady = (state_reg == FCS_IDLE);
  assign cyStart = (state_reg == FCS_ISSUE) && !cyBusy;

  // Next values of the command sequencer and its mode tracking.
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    cfi_next = cfi_reg;
    exit_next = exit_reg;
    step_next = step_reg;
    addrA_next = addrA_reg;
    dataA_next = dataA_reg;
    dataB_next = dataB_reg;
    rsp_next = rsp_reg;
    rspValid_next = 1'b0;
    refused_next = 1'b0;
    lockBit_next = lockBit_reg;
    spm_next = spm_reg;
    idm_next = idm_reg;
    unique case (state_reg)
      FCS_IDLE: if (cmdValid) begin
        if (refuse) begin
          rspValid_next = 1'b1;
          refused_next = 1'b1;
        end else begin
          state_next = FCS_ISSUE;
          op_next = reqOp;
          cfi_next = cmdCfi;
          exit_next = cmdExitLong;
          step_next = 3'h0;
          addrA_next = first_pair_address;
          dataA_next = first_pair_data;
          dataB_next = second_pair_data;
        end
      end
      FCS_ISSUE: if (cyStart) state_next = FCS_WAIT;
      FCS_WAIT: if (cyDone) begin
        if (step_reg == stepCount - 3'h1) state_next = FCS_DONE;
        else begin
          step_next = step_reg + 3'h1;
          state_next = FCS_ISSUE;
        end
      end
      FCS_DONE: begin
        state_next = FCS_IDLE;
        rspValid_next = 1'b1;
        rsp_next = cyData;
        if (cfi_reg) idm_next = 1'b1;
        else begin
          unique case (op_reg)
            fcs_pkg::FCS_OP_ID_ENTRY: idm_next = 1'b1;
            fcs_pkg::FCS_OP_ID_EXIT: idm_next = 1'b0;
            fcs_pkg::FCS_OP_BLOCK_B_STATUS: begin
              idm_next = 1'b1;
              lockBit_next = cyData[fcs_pkg::BLOCK_B_LOCK_BIT];
            end
            fcs_pkg::FCS_OP_SINGLE_PULSE_ENTER: spm_next = 1'b1;
            default: ;
          endcase
        end
      end
    endcase
  end

  // Registers of the command sequencer.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= FCS_IDLE;
      op_reg <= fcs_pkg::FCS_OP_READ;
      cfi_reg <= 1'b0;
      exit_reg <= 1'b0;
      step_reg <= 3'h0;
      addrA_reg <= '0;
      dataA_reg <= '0;
      dataB_reg <= '0;
      rsp_reg <= '0;
      rspValid_reg <= 1'b0;
      refused_reg <= 1'b0;
      lockBit_reg <= 1'b1;
      spm_reg <= 1'b0;
      idm_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      cfi_reg <= cfi_next;
      exit_reg <= exit_next;
      step_reg <= step_next;
      addrA_reg <= addrA_next;
      dataA_reg <= dataA_next;
      dataB_reg <= dataB_next;
      rsp_reg <= rsp_next;
      rspValid_reg <= rspValid_next;
      refused_reg <= refused_next;
      lockBit_reg <= lockBit_next;
      spm_reg <= spm_next;
      idm_reg <= idm_next;
    end
  end

  // Response and mode outputs come straight from registers.
  assign rspValid = rspValid_reg;
  assign rspRefused = refused_reg;
  assign rspData = rsp_reg;
  assign block_b_lock_bit = lockBit_reg;
  assign singlePulseMode = spm_reg;
  assign idMode = idm_reg;
endmodule : fcs_flash_host

// ==== verilog/fcs_pkg.sv ====
// Package of command codes, addresses and bus timing for the flash host.
package fcs_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'haaa;
  localparam logic [11:0] ADDR_CFI = 12'h055;
  localparam logic [11:0] ADDR_BLOCK_B_LOCK = 12'h080;
  localparam logic [7:0] DAT_UNLOCK1 = 8'haa;
  localparam logic [7:0] DAT_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_PROT_REG = 8'hc0;
  localparam logic [7:0] CMD_CONFIG = 8'hd0;
  localparam logic [7:0] CMD_DUAL = 8'he0;
  localparam logic [7:0] CMD_EXTENDED = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SINGLE_PULSE = 8'ha0;
  localparam logic [7:0] CMD_LOCKDOWN = 8'h60;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
  localparam logic [7:0] CMD_CFI = 8'h98;
  localparam logic [7:0] DAT_BLOCK_B_LOCK = 8'h00;
  localparam int BLOCK_B_LOCK_BIT = 1;
  // Bus cycle timing: setup, strobe and hold in nanoseconds, rounded up to whole clock cycles.
  localparam int CLK_NS = 50;
  localparam int T_SETUP_NS = 50;
  localparam int T_STROBE_NS = 100;
  localparam int T_HOLD_NS = 50;
  localparam int T_SETUP_CYC =
    (T_SETUP_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
    (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_STROBE_CYC =
    (T_STROBE_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
    (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_HOLD_CYC =
    (T_HOLD_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
    (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  // Host operations taken at the user port.
  typedef enum logic [3:0] {
    FCS_OP_READ = 4'h0,
    FCS_OP_PROGRAM = 4'h1,
    FCS_OP_DUAL = 4'h2,
    FCS_OP_CHIP_ERASE = 4'h3,
    FCS_OP_SECTOR_ERASE = 4'h4,
    FCS_OP_SINGLE_PULSE_ENTER = 4'h5,
    FCS_OP_SINGLE_PULSE_WRITE = 4'h6,
    FCS_OP_LOCKDOWN = 4'h7,
    FCS_OP_SUSPEND = 4'h8,
    FCS_OP_RESUME = 4'h9,
    FCS_OP_ID_ENTRY = 4'ha,
    FCS_OP_ID_EXIT = 4'hb,
    FCS_OP_PROT_PROGRAM = 4'hc,
    FCS_OP_BLOCK_B_LOCK = 4'hd,
    FCS_OP_BLOCK_B_STATUS = 4'he,
    FCS_OP_CONFIG = 4'hf
  } fcs_op_e;
endpackage : fcs_pkg

// ==== verilog/fcs_seq_rom.sv ====
// Lookup of the address and data for one step of a host command sequence.
`timescale 1ns/1ps
module fcs_seq_rom (
  input wire fcs_pkg::fcs_op_e op,
  input wire logic [2:0] step,
  input wire logic cfiOp,
  input wire logic exitLong,
  input wire logic [fcs_pkg::ADDR_W-1:0] addrA,
  input wire logic [fcs_pkg::ADDR_W-1:0] addrB,
  input wire logic [fcs_pkg::DATA_W-1:0] dataA,
  input wire logic [fcs_pkg::DATA_W-1:0] dataB,
  output logic [fcs_pkg::ADDR_W-1:0] stepAddr,
  output logic [fcs_pkg::DATA_W-1:0] stepData,
  output logic stepRead,
  output logic [2:0] stepCount
);
  // Widens a twelve-bit command address; upper bits are driven zero.
  function automatic logic [fcs_pkg::ADDR_W-1:0] cmdAddr(
    input logic [11:0] a
  );
    cmdAddr = {{(fcs_pkg::ADDR_W-12){1'b0}}, a};
  endfunction : cmdAddr

  // Widens a command code onto the low eight data lines.
  function automatic logic [fcs_pkg::DATA_W-1:0] cmdData(
    input logic [7:0] d
  );
    cmdData = {{(fcs_pkg::DATA_W-8){1'b0}}, d};
  endfunction : cmdData

  logic [7:0] thirdCode;
  logic [7:0] sixthCode;

  // Third and sixth cycle codes chosen by the operation.
  always_comb begin
    thirdCode = fcs_pkg::CMD_EXTENDED;
    sixthCode = fcs_pkg::CMD_CHIP_ERASE;
    unique case (op)
      fcs_pkg::FCS_OP_PROGRAM: thirdCode = fcs_pkg::CMD_PROGRAM;
      fcs_pkg::FCS_OP_DUAL: thirdCode = fcs_pkg::CMD_DUAL;
      fcs_pkg::FCS_OP_ID_ENTRY: thirdCode = fcs_pkg::CMD_ID_ENTRY;
      fcs_pkg::FCS_OP_BLOCK_B_STATUS: thirdCode = fcs_pkg::CMD_ID_ENTRY;
      fcs_pkg::FCS_OP_ID_EXIT: thirdCode = fcs_pkg::CMD_ID_EXIT;
      fcs_pkg::FCS_OP_PROT_PROGRAM: thirdCode = fcs_pkg::CMD_PROT_REG;
      fcs_pkg::FCS_OP_BLOCK_B_LOCK: thirdCode = fcs_pkg::CMD_PROT_REG;
      fcs_pkg::FCS_OP_CONFIG: thirdCode = fcs_pkg::CMD_CONFIG;
      fcs_pkg::FCS_OP_SECTOR_ERASE: sixthCode = fcs_pkg::CMD_SECTOR_ERASE;
      fcs_pkg::FCS_OP_SINGLE_PULSE_ENTER:
        sixthCode = fcs_pkg::CMD_SINGLE_PULSE;
      fcs_pkg::FCS_OP_LOCKDOWN: sixthCode = fcs_pkg::CMD_LOCKDOWN;
      default: ;
    endcase
  end

  // Address, data and direction of the requested step.
  always_comb begin
    stepAddr = cmdAddr(fcs_pkg::ADDR_UNLOCK1);
    stepData = cmdData(fcs_pkg::DAT_UNLOCK1);
    stepRead = 1'b0;
    stepCount = 3'h3;
    if (cfiOp) begin
      stepCount = 3'h1;
      stepAddr = cmdAddr(fcs_pkg::ADDR_CFI);
      stepData = cmdData(fcs_pkg::CMD_CFI);
    end else begin
      unique case (op)
        fcs_pkg::FCS_OP_READ: begin
          stepCount = 3'h1;
          stepRead = 1'b1;
          stepAddr = addrA;
        end
        fcs_pkg::FCS_OP_SINGLE_PULSE_WRITE: begin
          stepCount = 3'h1;
          stepAddr = addrA;
          stepData = dataA;
        end
        fcs_pkg::FCS_OP_SUSPEND, fcs_pkg::FCS_OP_RESUME: begin
          stepCount = 3'h1;
          stepAddr = addrA;
          stepData = cmdData(op == fcs_pkg::FCS_OP_SUSPEND ?
            fcs_pkg::CMD_SUSPEND : fcs_pkg::CMD_RESUME);
        end
        fcs_pkg::FCS_OP_ID_ENTRY: stepCount = 3'h3;
        fcs_pkg::FCS_OP_ID_EXIT: stepCount = exitLong ? 3'h3 : 3'h1;
        fcs_pkg::FCS_OP_DUAL: stepCount = 3'h5;
        fcs_pkg::FCS_OP_CHIP_ERASE, fcs_pkg::FCS_OP_SECTOR_ERASE,
        fcs_pkg::FCS_OP_SINGLE_PULSE_ENTER, fcs_pkg::FCS_OP_LOCKDOWN:
          stepCount = 3'h6;
        default: stepCount = 3'h4;
      endcase
      if (op == fcs_pkg::FCS_OP_ID_EXIT && !exitLong) begin
        stepAddr = addrA;
        stepData = cmdData(fcs_pkg::CMD_ID_EXIT);
      end else if (stepCount != 3'h1) begin
        unique case (step)
          3'h0, 3'h3: begin
            stepAddr = cmdAddr(fcs_pkg::ADDR_UNLOCK1);
            stepData = cmdData(fcs_pkg::DAT_UNLOCK1);
          end
          3'h1, 3'h4: begin
            stepAddr = cmdAddr(fcs_pkg::ADDR_UNLOCK2);
            stepData = cmdData(fcs_pkg::DAT_UNLOCK2);
          end
          3'h2: stepData = cmdData(thirdCode);
          default: begin
            stepAddr = cmdAddr(fcs_pkg::ADDR_UNLOCK1);
            stepData = cmdData(sixthCode);
          end
        endcase
        if (stepCount == 3'h5 && step == 3'h3) begin
          stepAddr = addrA;
          stepData = dataA;
        end else if (stepCount == 3'h5 && step == 3'h4) begin
          stepAddr = {addrA[fcs_pkg::ADDR_W-1:1], ~addrA[0]};
          stepData = dataB;
        end else if (stepCount == 3'h6 && step == 3'h5 &&
                     (op == fcs_pkg::FCS_OP_SECTOR_ERASE ||
                      op == fcs_pkg::FCS_OP_LOCKDOWN)) begin
          stepAddr = addrA;
        end else if (stepCount == 3'h4 && step == 3'h3) begin
          stepAddr = addrA;
          stepData = dataA;
          stepRead = (op == fcs_pkg::FCS_OP_BLOCK_B_STATUS);
          if (op == fcs_pkg::FCS_OP_BLOCK_B_LOCK ||
              op == fcs_pkg::FCS_OP_BLOCK_B_STATUS) begin
            stepAddr = cmdAddr(fcs_pkg::ADDR_BLOCK_B_LOCK);
            stepData = cmdData(fcs_pkg::DAT_BLOCK_B_LOCK);
          end else if (op == fcs_pkg::FCS_OP_CONFIG) begin
            stepData = {{(fcs_pkg::DATA_W-1){1'b0}}, dataA[0]};
          end
        end
      end
    end
  end
  // addrB is reserved for callers that pass an explicit second address.
  logic unusedB;
  assign unusedB = ^addrB;
endmodule : fcs_seq_rom
